// [rtl/smc_switch_matrix.sv]
// register bank and enable logic of the switch matrix
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module smc_switch_matrix
  import smc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output smc_switch_type sw_enable
);

  smc_state_type st_reg;
  smc_state_type st_next;

  // one-hot vector for a switch position
  function automatic logic [15:0] one_hot(input logic [3:0] pos);
    one_hot = 16'h0001 << pos;
  endfunction

  // drive group decode
  function automatic logic [15:0] dec_drv(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      4'h1: v = SMC_DRV_CAL_SW;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
        v = one_hot(code - 4'h1);
      end
      4'h9: v = SMC_DRV_MASK;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // tia group decode, ninth and tenth switch excluded
  function automatic logic [15:0] dec_tia(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      4'h1, 4'h2, 4'h3, 4'h4: begin
        v = one_hot(code - 4'h1);
      end
      4'h8: v = SMC_TIA_CAL_SW;
      4'h9: v = SMC_TIA_MASK;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // negative group decode
  function automatic logic [15:0] dec_neg(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      4'h5, 4'h9: begin
        v = one_hot(code - 4'h1);
      end
      4'hb, 4'hc, 4'hd, 4'he: begin
        v = SMC_NEG_LDO_B_SW;
      end
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // positive group decode
  function automatic logic [15:0] dec_pos(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      4'h1: v = SMC_POS_CAL_SW;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb: begin
        v = one_hot(code - 4'h1);
      end
      4'hd, 4'he: v = SMC_POS_LDO_B_SW;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // writes, read mux and switch selection
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;
    if (bus_wr) begin
      case (bus_addr)
        SMC_CFG_OFF: st_next.cfg = bus_wdata[18:0];
        SMC_DRV_FULL_OFF: begin
          st_next.full.drv = bus_wdata[15:0] & SMC_DRV_MASK;
        end
        SMC_NEG_FULL_OFF: begin
          st_next.full.neg = bus_wdata[15:0] & SMC_NEG_MASK;
        end
        SMC_POS_FULL_OFF: begin
          st_next.full.pos = bus_wdata[15:0] & SMC_POS_MASK;
        end
        SMC_TIA_FULL_OFF: begin
          st_next.full.tia = bus_wdata[15:0] & SMC_TIA_MASK;
        end
        default: st_next.cfg = st_reg.cfg;
      endcase
    end
    if (bus_rd) begin
      case (bus_addr)
        SMC_CFG_OFF: st_next.rdata = {13'h0000, st_reg.cfg};
        SMC_DRV_FULL_OFF: st_next.rdata = {16'h0000, st_reg.full.drv};
        SMC_NEG_FULL_OFF: st_next.rdata = {16'h0000, st_reg.full.neg};
        SMC_POS_FULL_OFF: st_next.rdata = {16'h0000, st_reg.full.pos};
        SMC_TIA_FULL_OFF: st_next.rdata = {16'h0000, st_reg.full.tia};
        SMC_DRV_STA_OFF: st_next.rdata = {16'h0000, st_reg.sw.drv};
        SMC_POS_STA_OFF: st_next.rdata = {16'h0000, st_reg.sw.pos};
        SMC_NEG_STA_OFF: st_next.rdata = {16'h0000, st_reg.sw.neg};
        SMC_TIA_STA_OFF: st_next.rdata = {16'h0000, st_reg.sw.tia};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // path select between per-switch bits and group codes
    if (st_reg.cfg[SMC_SEL_BIT]) begin
      st_next.sw = st_reg.full;
    end else begin
      st_next.sw.drv = dec_drv(st_reg.cfg[SMC_DRV_LSB +: 4]);
      st_next.sw.neg = dec_neg(st_reg.cfg[SMC_NEG_LSB +: 4]);
      st_next.sw.pos = dec_pos(st_reg.cfg[SMC_POS_LSB +: 4]);
      st_next.sw.tia = dec_tia(st_reg.cfg[SMC_TIA_LSB +: 4]);
    end
    // ninth and tenth tia switches follow their own bits on both paths
    st_next.sw.tia[SMC_T9_SW] = st_reg.cfg[SMC_T9_BIT];
    st_next.sw.tia[SMC_T10_SW] = st_reg.cfg[SMC_T10_BIT];
  end

  // state register, all switches open at reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg.cfg <= SMC_CFG_RST;
      st_reg.full <= {4{SMC_FULL_RST}};
      st_reg.sw <= {4{SMC_SW_RST}};
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign bus_rdata = st_reg.rdata;
  assign sw_enable = st_reg.sw;

  // configuration comes out of reset at its documented value
  AST_CFG_RST: assert property (@(posedge ref_clk)
    $fell(rst) |-> st_reg.cfg == 19'h0ffff)
    else $error("config not at reset value");

  // per-switch registers come out of reset cleared
  AST_FULL_RST: assert property (@(posedge ref_clk)
    $fell(rst) |-> st_reg.full == 64'h0)
    else $error("per-switch registers not cleared");

  // group path drives the drive switches from the code
  AST_GROUP_PATH: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[3:0] == 4'h3)
    |=> sw_enable.drv == 16'h0004)
    else $error("drive code 3 did not close only D3");

  // per-switch path copies the registers
  AST_FULL_PATH: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.cfg[16] |=> sw_enable.neg == $past(st_reg.full.neg))
    else $error("per-switch path not followed");

  // per-switch writes stay away from switches while grouped
  AST_FULL_HIDDEN: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[3:0] == 4'hf) [*2]
    |=> sw_enable.drv == 16'h0000)
    else $error("per-switch bit leaked into group mode");

  // tenth tia switch follows bit 18 one cycle later
  AST_T10: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st_reg.cfg[18]) |=> sw_enable.tia[9] ##1 1'b1)
    else $error("tenth tia switch did not close");

  // ninth tia switch follows bit 17 one cycle later
  AST_T9: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(st_reg.cfg[17]) |=> !sw_enable.tia[8])
    else $error("ninth tia switch did not open");

  // all-closed tia code leaves the ninth and tenth switches open
  AST_TIA_ALL: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[15:12] == 4'h9 && st_reg.cfg[18:17] == 2'b00)
    |=> sw_enable.tia == 16'h08ff)
    else $error("tia all-closed code wrong");

  // tia calibration code closes only the cal switch
  AST_TIA_CAL: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[15:12] == 4'h8 && st_reg.cfg[18:17] == 2'b00)
    |=> sw_enable.tia == 16'h0800)
    else $error("tia cal code wrong");

  // negative code 5 closes only N5
  AST_NEG_N5: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[11:8] == 4'h5)
    |=> sw_enable.neg == 16'h0010)
    else $error("negative code 5 wrong");

  // negative codes b to e close only the ldo tie switch
  AST_NEG_LDO: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[11:8] inside {[4'hb:4'he]})
    |=> sw_enable.neg == 16'h0800)
    else $error("negative ldo tie code wrong");

  // positive code 4 closes only P4
  AST_POS_P4: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[7:4] == 4'h4)
    |=> sw_enable.pos == 16'h0008)
    else $error("positive code 4 wrong");

  // status read returns the present switch state
  AST_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_rd && bus_addr == 16'h21b8)
    |=> bus_rdata == {16'h0000, $past(sw_enable.neg)})
    else $error("negative status read wrong");

  // drive code 9 closes every drive switch
  AST_DRV_ALL: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[3:0] == 4'h9)
    |=> sw_enable.drv == 16'h00ff)
    else $error("drive all-closed code wrong");

  // reserved bits of a per-switch register read zero
  AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_rd && bus_addr == 16'h2150)
    |=> bus_rdata[31:8] == 24'h000000)
    else $error("reserved drive bits not zero");

  // reserved drive codes open the whole group
  AST_RSVD_CODE: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_reg.cfg[16] && st_reg.cfg[3:0] inside {[4'ha:4'hf]})
    |=> sw_enable.drv == 16'h0000)
    else $error("reserved drive code closed a switch");

endmodule
`default_nettype wire

// [rtl/smc_pkg.sv]
// constants and carrier types of the switch matrix control block
package smc_pkg;

  // register byte offsets
  localparam logic [15:0] SMC_CFG_OFF = 16'h200c;
  localparam logic [15:0] SMC_DRV_FULL_OFF = 16'h2150;
  localparam logic [15:0] SMC_NEG_FULL_OFF = 16'h2154;
  localparam logic [15:0] SMC_POS_FULL_OFF = 16'h2158;
  localparam logic [15:0] SMC_TIA_FULL_OFF = 16'h215c;
  localparam logic [15:0] SMC_DRV_STA_OFF = 16'h21b0;
  localparam logic [15:0] SMC_POS_STA_OFF = 16'h21b4;
  localparam logic [15:0] SMC_NEG_STA_OFF = 16'h21b8;
  localparam logic [15:0] SMC_TIA_STA_OFF = 16'h21bc;

  // reset values
  localparam logic [18:0] SMC_CFG_RST = 19'h0ffff;
  localparam logic [15:0] SMC_FULL_RST = 16'h0000;
  localparam logic [15:0] SMC_SW_RST = 16'h0000;

  // configuration field positions
  localparam int unsigned SMC_SEL_BIT = 16;
  localparam int unsigned SMC_T9_BIT = 17;
  localparam int unsigned SMC_T10_BIT = 18;
  localparam int unsigned SMC_TIA_LSB = 12;
  localparam int unsigned SMC_NEG_LSB = 8;
  localparam int unsigned SMC_POS_LSB = 4;
  localparam int unsigned SMC_DRV_LSB = 0;

  // switch positions inside each group vector
  localparam int unsigned SMC_T9_SW = 8;
  localparam int unsigned SMC_T10_SW = 9;
  localparam logic [15:0] SMC_TIA_CAL_SW = 16'h0800;
  localparam logic [15:0] SMC_NEG_LDO_B_SW = 16'h0800;
  localparam logic [15:0] SMC_POS_LDO_B_SW = 16'h1000;
  localparam logic [15:0] SMC_POS_CAL_SW = 16'h0001;
  localparam logic [15:0] SMC_DRV_CAL_SW = 16'h0001;

  // implemented bits of each per-switch register and group
  localparam logic [15:0] SMC_DRV_MASK = 16'h00ff;
  localparam logic [15:0] SMC_NEG_MASK = 16'h1fff;
  localparam logic [15:0] SMC_POS_MASK = 16'h1fff;
  localparam logic [15:0] SMC_TIA_MASK = 16'h08ff;

  typedef struct packed {
    logic [15:0] drv;
    logic [15:0] neg;
    logic [15:0] pos;
    logic [15:0] tia;
  } smc_switch_type;

  typedef struct packed {
    logic [18:0] cfg;
    smc_switch_type full;
    smc_switch_type sw;
    logic [31:0] rdata;
  } smc_state_type;

endpackage

// [dv/tb_top.sv]
// self-checking bench of the switch matrix register bank and enables
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import smc_pkg::*;
;
  logic ref_clk;
  logic rst;
  logic [15:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  smc_switch_type sw_enable;
  int n_mismatch;
  int check_count;

  smc_switch_matrix dut (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sw_enable(sw_enable));

  // 250 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_sw(input string name, input smc_switch_type exp);
    check_count++;
    if (sw_enable !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, sw_enable);
    end
  endtask

  // one-cycle write strobe, returns at the taking edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data sampled in the following cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk32(name, exp, d);
  endtask

  // write config and wait for the switch flop to follow
  task automatic wr_cfg_settle(input logic [31:0] d);
    wr(SMC_CFG_OFF, d);
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk_status(input smc_switch_type e);
    rd_chk("drv_state", SMC_DRV_STA_OFF, {16'h0000, e.drv});
    rd_chk("pos_state", SMC_POS_STA_OFF, {16'h0000, e.pos});
    rd_chk("neg_state", SMC_NEG_STA_OFF, {16'h0000, e.neg});
    rd_chk("tia_state", SMC_TIA_STA_OFF, {16'h0000, e.tia});
  endtask

  // expected group decodes
  function automatic smc_switch_type grp_exp(input logic [3:0] c);
    smc_switch_type e;
    e = '0;
    if (c >= 4'h1 && c <= 4'h8) e.drv = 16'h0001 << (c - 4'h1);
    if (c == 4'h9) e.drv = 16'h00ff;
    if (c >= 4'h1 && c <= 4'h4) e.tia = 16'h0001 << (c - 4'h1);
    if (c == 4'h8) e.tia = 16'h0800;
    if (c == 4'h9) e.tia = 16'h08ff;
    if (c == 4'h5) e.neg = 16'h0010;
    if (c == 4'h9) e.neg = 16'h0100;
    if (c >= 4'hb && c <= 4'he) e.neg = 16'h0800;
    if (c == 4'h1) e.pos = 16'h0001;
    if (c >= 4'h3 && c <= 4'h9) e.pos = 16'h0001 << (c - 4'h1);
    if (c == 4'hb) e.pos = 16'h0400;
    if (c == 4'hd || c == 4'he) e.pos = 16'h1000;
    return e;
  endfunction

  task automatic test_reset();
    chk_sw("sw_after_reset", '0);
    rd_chk("cfg_reset", SMC_CFG_OFF, 32'h0000ffff);
    // read data stands one cycle only, then drops back to zero
    @(posedge ref_clk);
    #1;
    chk32("rdata_idle", 32'h0, bus_rdata);
    rd_chk("drv_full_reset", SMC_DRV_FULL_OFF, 32'h0);
    rd_chk("neg_full_reset", SMC_NEG_FULL_OFF, 32'h0);
    rd_chk("pos_full_reset", SMC_POS_FULL_OFF, 32'h0);
    rd_chk("tia_full_reset", SMC_TIA_FULL_OFF, 32'h0);
    chk_status('0);
  endtask

  task automatic test_group_codes();
    for (int i = 0; i < 16; i++) begin
      wr_cfg_settle({16'h0000, {4{i[3:0]}}});
      chk_sw("group_code", grp_exp(i[3:0]));
      chk_status(grp_exp(i[3:0]));
    end
  endtask

  task automatic test_tia_direct();
    smc_switch_type e;
    e = grp_exp(4'h8);
    for (int i = 1; i < 4; i++) begin
      wr_cfg_settle({13'h0, i[1:0], 1'b0, 16'h8888});
      e.tia = 16'h0800 | {6'h0, i[1:0], 8'h00};
      chk_sw("tia_direct", e);
    end
  endtask

  task automatic test_per_switch();
    smc_switch_type e;
    wr_cfg_settle(32'h0000ffff);
    wr(SMC_DRV_FULL_OFF, 32'hffffffff);
    wr(SMC_NEG_FULL_OFF, 32'hffffffff);
    wr(SMC_POS_FULL_OFF, 32'hffffffff);
    wr(SMC_TIA_FULL_OFF, 32'hffffffff);
    @(posedge ref_clk);
    #1;
    chk_sw("full_before_select", '0);
    rd_chk("drv_full", SMC_DRV_FULL_OFF, 32'h000000ff);
    rd_chk("neg_full", SMC_NEG_FULL_OFF, 32'h00001fff);
    rd_chk("pos_full", SMC_POS_FULL_OFF, 32'h00001fff);
    rd_chk("tia_full", SMC_TIA_FULL_OFF, 32'h000008ff);
    wr_cfg_settle(32'h0001ffff);
    e = '{drv: 16'h00ff, neg: 16'h1fff, pos: 16'h1fff, tia: 16'h08ff};
    chk_sw("full_selected", e);
    wr(SMC_DRV_FULL_OFF, 32'h00000081);
    wr_cfg_settle(32'hffffffff);
    e.drv = 16'h0081;
    e.tia = 16'h0bff;
    chk_sw("full_with_t9_t10", e);
    rd_chk("cfg_reserved", SMC_CFG_OFF, 32'h0007ffff);
    wr(SMC_DRV_STA_OFF, 32'h00000000);
    chk_status(e);
    rd_chk("unmapped", 16'h2000, 32'h0);
    wr_cfg_settle(32'h00000000);
    chk_sw("back_to_groups", '0);
  endtask

  // hibernate tie-off: software closes both ldo tie pairs through the per-switch registers
  task automatic test_hibernate();
    smc_switch_type e;
    e = '0;
    e.neg = 16'h0c00;
    e.pos = 16'h1800;
    wr(SMC_NEG_FULL_OFF, 32'h00000c00);
    wr(SMC_POS_FULL_OFF, 32'h00001800);
    wr(SMC_DRV_FULL_OFF, 32'h00000000);
    wr(SMC_TIA_FULL_OFF, 32'h00000000);
    wr_cfg_settle(32'h0001ffff);
    chk_sw("hibernate_ties", e);
    chk_status(e);
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    n_mismatch = 0;
    check_count = 0;
    rst = 1'b1;
    bus_addr = 16'h0;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    test_reset();
    test_group_codes();
    test_tia_direct();
    test_per_switch();
    test_hibernate();
    summarize();
  end
endmodule
`default_nettype wire
